// ==== design/hcb_defines.svh ====
// Constants for the host command front end: opcodes, status codes, mode codes and timings.
`ifndef HCB_DEFINES_SVH
`define HCB_DEFINES_SVH

`define HCB_CLK_PERIOD_NS 10
`define HCB_NS_PER_US     1000
`define HCB_UART_BAUD     115200
`define HCB_NS_PER_S      1000000000

`define HCB_OP_STATUS 8'hC0
`define HCB_OP_WREG   8'h18
`define HCB_OP_RREG   8'h19
`define HCB_OP_WBUF   8'h1A
`define HCB_OP_RBUF   8'h1B
`define HCB_REG_HDR   2'h2
`define HCB_BUF_HDR   2'h1

`define HCB_MODE_RC    3'h2
`define HCB_MODE_XO    3'h3
`define HCB_MODE_FS    3'h4
`define HCB_MODE_RX    3'h5
`define HCB_MODE_TX    3'h6
`define HCB_MODE_SLEEP 3'h7

`define HCB_CST_OK      3'h1
`define HCB_CST_TIMEOUT 3'h3
`define HCB_CST_ERROR   3'h4

`define HCB_T_WAKE_COLD_US 1700
`define HCB_T_WAKE_WARM_US 250
`define HCB_T_RC_XO_US     53
`define HCB_T_RC_FS_US     83
`define HCB_T_RC_RX_US     115
`define HCB_T_RC_TX_US     102
`define HCB_T_XO_FS_US     40
`define HCB_T_XO_TX_US     54
`define HCB_T_XO_RX_US     68
`define HCB_T_FS_RX_US     34
`define HCB_T_FS_TX_US     27
`define HCB_T_RX_FS_US     13
`define HCB_T_RX_TX_US     39
`define HCB_T_TX_FS_US     31
`define HCB_T_TX_RX_US     60
`define HCB_T_OTHER_US     1
`define HCB_T_WDOG_US      50000

`endif

// ==== design/hcb_pkg.sv ====
// Types shared by the host command front end.
package hcb_pkg;
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000, ST_IDLE = 3'b001, ST_XFER = 3'b010, ST_EXEC = 3'b011,
    ST_SWITCH = 3'b100, ST_SLEEP = 3'b101, ST_WAKE = 3'b110
  } hcb_state_t;

  typedef enum logic [3:0] {
    UF_REST = 4'b0000, UF_CLASS = 4'b0001, UF_HDR = 4'b0010, UF_LEN = 4'b0011, UF_PAR = 4'b0100,
    UF_RDREQ = 4'b0101, UF_RDLD = 4'b0110, UF_RDTX = 4'b0111, UF_STAT = 4'b1000
  } hcb_uframe_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] cst;
    logic       rsv;
    logic       busy;
  } hcb_status_t;

  typedef struct packed {
    logic       mode_go;
    logic [2:0] target;
    logic [2:0] cst;
  } hcb_exec_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } hcb_byte_t;
endpackage

// ==== design/hcb_uart.sv ====
// Byte serial port: receiver and transmitter, LSB first, optional parity, one stop bit.
`timescale 1ns/10ps
`include "hcb_defines.svh"
module hcb_uart
  import hcb_pkg::*;
#(
  parameter int unsigned DIV    = `HCB_NS_PER_S / (`HCB_UART_BAUD * `HCB_CLK_PERIOD_NS),
  parameter bit          PAR_EN = 1'b1,
  parameter bit          PAR_OD = 1'b0
) (
  input  wire logic       clk,     // System clock.
  input  wire logic       resetn,  // Asynchronous reset, active low.
  input  wire logic       rxd,     // Serial input pin.
  output hcb_byte_t       rx_out,  // Received byte, valid for one cycle.
  output logic            rx_err,  // Parity or stop bit error, one cycle.
  input  wire logic       tx_go,   // Start sending tx_data.
  input  wire logic [7:0] tx_data, // Byte to send.
  output logic            txd,     // Serial output pin.
  output logic            tx_busy  // Transmitter occupied.
);
  localparam int unsigned NB = PAR_EN ? 11 : 10;
  typedef struct packed {
    logic        s1, s2;
    logic        rx_on;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    hcb_byte_t   rx_out;
    logic        rx_err;
    logic        tx_on;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [10:0] tx_sh;
  } hcb_uart_st_t;
  hcb_uart_st_t q, n;

  // Receiver samples mid-bit; transmitter shifts a whole frame out of one register.
  always_comb begin
    n = q;
    n.s1 = rxd;
    n.s2 = q.s1;
    n.rx_out.valid = 1'b0;
    n.rx_err = 1'b0;
    if (!q.rx_on) begin
      if (!q.s2) begin
        n.rx_on = 1'b1;
        n.rx_cnt = 16'(DIV / 2);
        n.rx_bit = '0;
        n.rx_par = PAR_OD;
      end
    end else if (q.rx_cnt != '0) begin
      n.rx_cnt = q.rx_cnt - 1'b1;
    end else begin
      n.rx_cnt = 16'(DIV - 1);
      n.rx_bit = q.rx_bit + 1'b1;
      if (q.rx_bit == '0) begin
        n.rx_on = ~q.s2;  // A glitch that is high again mid-bit is no start bit.
      end else if (q.rx_bit <= 4'h8) begin
        n.rx_sh = {q.s2, q.rx_sh[7:1]};
        n.rx_par = q.rx_par ^ q.s2;
      end else if (PAR_EN && q.rx_bit == 4'h9) begin
        n.rx_par = q.rx_par ^ q.s2;
      end else begin
        n.rx_on = 1'b0;
        n.rx_out.data = q.rx_sh;
        if (q.s2 && !(PAR_EN && q.rx_par)) begin
          n.rx_out.valid = 1'b1;
        end else begin
          n.rx_err = 1'b1;
        end
      end
    end
    if (!q.tx_on) begin
      if (tx_go) begin
        n.tx_on = 1'b1;
        n.tx_cnt = 16'(DIV - 1);
        n.tx_bit = 4'(NB - 1);
        n.tx_sh = {1'b1, PAR_EN ? (^tx_data ^ PAR_OD) : 1'b1, tx_data, 1'b0};
      end
    end else if (q.tx_cnt != '0) begin
      n.tx_cnt = q.tx_cnt - 1'b1;
    end else begin
      n.tx_cnt = 16'(DIV - 1);
      n.tx_sh = {1'b1, q.tx_sh[10:1]};
      n.tx_bit = q.tx_bit - 1'b1;
      if (q.tx_bit == '0) begin
        n.tx_on = 1'b0;
      end
    end
  end

  // Line idles high, so the synchroniser and shifter reset to ones.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
      q.tx_sh <= '1;
    end else begin
      q <= n;
    end
  end

  assign rx_out = q.rx_out;
  assign rx_err = q.rx_err;
  assign txd = q.tx_sh[0];
  assign tx_busy = q.tx_on;
endmodule // hcb_uart

// ==== design/hcb_frontend.sv ====
// Host command front end: serial framing, busy handshake, mode switch timing and status byte.
// Behaviour
// - Busy stays high through every transaction and while its command is processed; asynchronous port raises it only after the opcode byte.
// - Busy drops only when ready for a new command or settled in a mode.
// - Switch time counts from select rising edge ending the transaction to busy fall.
// - Wake from sleep takes 1700 us cold, 250 us with retained memory.
// - From RC idle: 53 crystal idle, 83 synth, 115 receive, 102 transmit us.
// - Crystal idle: 40 synth, 54 transmit, 68 receive; synth: 34 receive, 27 transmit.
// - Receive: 13 synth, 39 transmit; transmit: 31 synth, 60 receive us.
// - Entering synth mode, busy falls only after synthesizer lock.
// - Entering receive, busy falls once the receive chain is ready.
// - Entering transmit, busy falls when amplifier ramp ends and preamble starts.
// - A parameterless command is its opcode byte alone on either port.
// - Synchronous port: parameters follow opcode; select rising edge ends the command.
// - Synchronous port shifts the status byte out during every byte shifted in.
// - Asynchronous port: opcode, parameter count, then that many parameters.
// - Asynchronous reads: count byte after address, device returns that many bytes.
// - Status query 0xC0 accepted anytime; answered in-frame or as next byte; asynchronous port takes it only when idle.
// - Status: mode bits 7:5, command status 4:2, bit 1 reserved, bit 0 busy.
// - Mode codes: RC idle 2, crystal idle 3, synth 4, receive 5, transmit 6.
// - Status codes: 1 ok, 2 data, 3 timeout, 4 bad command, 5 fail, 6 sent.
// - A watchdog aborts overlong transactions with timeout status; host may disable it.
`timescale 1ns/10ps
`include "hcb_defines.svh"
module hcb_frontend
  import hcb_pkg::*;
#(
  parameter int unsigned US_CYC        = `HCB_NS_PER_US / `HCB_CLK_PERIOD_NS,
  parameter int unsigned WAKE_COLD_CYC = `HCB_T_WAKE_COLD_US * US_CYC,
  parameter int unsigned WAKE_WARM_CYC = `HCB_T_WAKE_WARM_US * US_CYC,
  parameter int unsigned WDOG_CYC      = `HCB_T_WDOG_US * US_CYC
) (
  input  wire logic       clk,           // System clock, 100 MHz.
  input  wire logic       resetn,        // Asynchronous reset, active low.
  input  wire logic       use_uart,      // 1 selects the asynchronous port.
  input  wire logic       port_select_n, // Synchronous port select pin, active low.
  input  wire logic       spi_sck,       // Synchronous port clock pin.
  input  wire logic       spi_mosi,      // Synchronous port data in pin.
  input  wire logic       uart_rxd,      // Asynchronous port data in pin.
  output logic            serial_out,    // Shared data out pin.
  output logic            busy,          // Busy pin, high while busy.
  input  wire logic       calib_done,    // Start-up calibration finished.
  input  wire logic       synth_lock,    // Synthesizer loop locked.
  input  wire logic       rx_ready,      // Receive chain ready.
  input  wire logic       tx_ramp_done,  // Amplifier ramp done, preamble starts.
  input  wire logic       wdog_en,       // Transaction watchdog enable.
  input  wire logic       wake_evt,      // Timer wake from sleep, one cycle.
  input  wire logic       retained,      // Memory retained during sleep.
  input  wire logic       op_noparam,    // Core: cmd_opcode takes no parameters.
  output logic            cmd_valid,     // Command complete, one cycle.
  output logic [7:0]      cmd_opcode,    // Opcode of the current command.
  output hcb_byte_t       par_out,       // Parameter byte stream.
  output logic            rd_req,        // Request next read byte, one cycle.
  input  wire logic [7:0] rd_data,       // Read byte, sampled in the cycle rd_req is high.
  input  wire logic       exec_done,     // Core finished the command, one cycle.
  input  hcb_exec_t       exec_resp,     // Core result with exec_done.
  input  wire logic       stat_evt,      // Core status event, one cycle.
  input  wire logic [2:0] stat_code,     // Status code with stat_evt.
  output hcb_status_t     status_out     // Current status byte.
);
  localparam int CW = 24;
  typedef struct packed {
    hcb_state_t  st;
    hcb_uframe_t uf;
    logic        nss1, nss2, nss_q, sck1, sck2, sck_q, mosi1, mosi2;
    logic [2:0]  bitcnt;
    logic [7:0]  rx_sh, tx_sh;
    logic        spi_act, got_op, warm;
    logic [7:0]  opcode, left;
    logic [1:0]  hdr;
    logic [2:0]  mode, cst, tgt;
    logic [CW-1:0] cnt;
    logic        busy, cmd_valid, rd_req, tx_go, pin_out;
    logic [7:0]  tx_byte;
    hcb_byte_t   par;
  } hcb_fe_st_t;
  hcb_fe_st_t q, n;

  hcb_byte_t   urx;
  logic        urx_err, utxd, utx_busy;
  logic        nss_fall, nss_rise, sck_rise, sck_fall, spi_byte;
  logic [7:0]  spi_data;
  hcb_status_t stat_now;
  logic        fin, abort;
  logic [2:0]  abort_cst;

  hcb_uart u_uart (
    .clk     (clk),
    .resetn  (resetn),
    .rxd     (uart_rxd),
    .rx_out  (urx),
    .rx_err  (urx_err),
    .tx_go   (q.tx_go),
    .tx_data (q.tx_byte),
    .txd     (utxd),
    .tx_busy (utx_busy)
  );

  // Switch times by transition; pairs not listed settle in one microsecond.
  function automatic logic [CW-1:0] sw_cyc(input logic [2:0] f, input logic [2:0] t);
    int unsigned us;
    case ({f, t})
      {`HCB_MODE_RC, `HCB_MODE_XO}: us = `HCB_T_RC_XO_US;
      {`HCB_MODE_RC, `HCB_MODE_FS}: us = `HCB_T_RC_FS_US;
      {`HCB_MODE_RC, `HCB_MODE_RX}: us = `HCB_T_RC_RX_US;
      {`HCB_MODE_RC, `HCB_MODE_TX}: us = `HCB_T_RC_TX_US;
      {`HCB_MODE_XO, `HCB_MODE_FS}: us = `HCB_T_XO_FS_US;
      {`HCB_MODE_XO, `HCB_MODE_TX}: us = `HCB_T_XO_TX_US;
      {`HCB_MODE_XO, `HCB_MODE_RX}: us = `HCB_T_XO_RX_US;
      {`HCB_MODE_FS, `HCB_MODE_RX}: us = `HCB_T_FS_RX_US;
      {`HCB_MODE_FS, `HCB_MODE_TX}: us = `HCB_T_FS_TX_US;
      {`HCB_MODE_RX, `HCB_MODE_FS}: us = `HCB_T_RX_FS_US;
      {`HCB_MODE_RX, `HCB_MODE_TX}: us = `HCB_T_RX_TX_US;
      {`HCB_MODE_TX, `HCB_MODE_FS}: us = `HCB_T_TX_FS_US;
      {`HCB_MODE_TX, `HCB_MODE_RX}: us = `HCB_T_TX_RX_US;
      default: us = `HCB_T_OTHER_US;
    endcase
    return CW'(us * US_CYC);
  endfunction

  // Analog readiness that must also be seen before busy may fall.
  function automatic logic tgt_ready(input logic [2:0] t);
    case (t)
      `HCB_MODE_FS: return synth_lock;
      `HCB_MODE_RX: return rx_ready;
      `HCB_MODE_TX: return tx_ramp_done;
      default: return 1'b1;
    endcase
  endfunction

  // Edges come from the second and third sync stages, never from the first.
  assign nss_fall = q.nss_q & ~q.nss2;
  assign nss_rise = ~q.nss_q & q.nss2;
  assign sck_rise = ~q.sck_q & q.sck2;
  assign sck_fall = q.sck_q & ~q.sck2;
  assign spi_byte = sck_rise & ~q.nss2 & (q.bitcnt == 3'h7) & ~use_uart;
  assign spi_data = {q.rx_sh[6:0], q.mosi2};
  assign stat_now = '{mode: q.mode, cst: q.cst, rsv: 1'b0, busy: q.busy};

  // Whole next-state function of the front end.
  always_comb begin
    n = q;
    fin = 1'b0;
    abort = 1'b0;
    abort_cst = `HCB_CST_TIMEOUT;
    n.cmd_valid = 1'b0;
    n.par.valid = 1'b0;
    n.rd_req = 1'b0;
    n.tx_go = 1'b0;
    n.nss1 = port_select_n;
    n.nss2 = q.nss1;
    n.nss_q = q.nss2;
    n.sck1 = spi_sck;
    n.sck2 = q.sck1;
    n.sck_q = q.sck2;
    n.mosi1 = spi_mosi;
    n.mosi2 = q.mosi1;
    if (q.cnt != '1) begin
      n.cnt = q.cnt + 1'b1;
    end
    if (stat_evt) begin
      n.cst = stat_code;
    end
    // Status shifts out on every byte, busy or not; mode 0 timing, MSB first.
    if (nss_fall) begin
      n.bitcnt = '0;
      n.tx_sh = stat_now;
    end else if (!q.nss2) begin
      if (sck_rise) begin
        n.rx_sh = spi_data;
        n.bitcnt = q.bitcnt + 1'b1;
      end
      if (sck_fall) begin
        n.tx_sh = (q.bitcnt == '0) ? stat_now : {q.tx_sh[6:0], 1'b0};
      end
    end
    unique case (q.st)
      ST_BOOT: begin
        if (calib_done) begin
          n.mode = `HCB_MODE_RC;
          n.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!use_uart && nss_fall) begin
          n.st = ST_XFER;
          n.spi_act = 1'b1;
          n.got_op = 1'b0;
          n.cnt = '0;
        end else if (use_uart && urx.valid) begin
          n.st = ST_XFER;
          n.cnt = '0;
          n.opcode = urx.data;
          if (urx.data == `HCB_OP_STATUS) begin
            n.uf = UF_STAT;
            n.tx_go = 1'b1;
            n.tx_byte = stat_now;
          end else if (urx.data == `HCB_OP_WREG || urx.data == `HCB_OP_RREG) begin
            n.uf = UF_HDR;
            n.hdr = `HCB_REG_HDR;
          end else if (urx.data == `HCB_OP_WBUF || urx.data == `HCB_OP_RBUF) begin
            n.uf = UF_HDR;
            n.hdr = `HCB_BUF_HDR;
          end else begin
            n.uf = UF_CLASS;
          end
        end
      end
      ST_XFER: begin
        if (wdog_en && q.cnt >= CW'(WDOG_CYC)) begin
          abort = 1'b1;
        end else if (!use_uart) begin
          if (spi_byte && q.spi_act) begin
            if (!q.got_op) begin
              n.opcode = spi_data;
              n.got_op = 1'b1;
            end else begin
              n.par = '{valid: 1'b1, data: spi_data};
            end
          end
          if (nss_rise) begin
            if (q.spi_act && q.got_op && q.opcode != `HCB_OP_STATUS) begin
              fin = 1'b1;
            end else begin
              n.st = ST_IDLE;
            end
            n.spi_act = 1'b0;
          end
        end else if (urx_err) begin
          abort = 1'b1;
          abort_cst = `HCB_CST_ERROR;
        end else begin
          unique case (q.uf)
            UF_CLASS: begin
              if (op_noparam) begin
                fin = 1'b1;
              end else begin
                n.uf = UF_LEN;
              end
            end
            UF_HDR: begin
              if (urx.valid) begin
                n.par = urx;
                n.hdr = q.hdr - 1'b1;
                if (q.hdr == 2'h1) begin
                  n.uf = UF_LEN;
                end
              end
            end
            UF_LEN: begin
              if (urx.valid) begin
                n.left = urx.data;
                if (urx.data == '0) begin
                  fin = 1'b1;
                end else if (q.opcode == `HCB_OP_RREG || q.opcode == `HCB_OP_RBUF) begin
                  n.uf = UF_RDREQ;
                end else begin
                  n.uf = UF_PAR;
                end
              end
            end
            UF_PAR: begin
              if (urx.valid) begin
                n.par = urx;
                n.left = q.left - 1'b1;
                if (q.left == 8'h01) begin
                  fin = 1'b1;
                end
              end
            end
            UF_RDREQ: begin
              n.rd_req = 1'b1;
              n.uf = UF_RDLD;
            end
            UF_RDLD: begin
              n.tx_go = 1'b1;
              n.tx_byte = rd_data;
              n.left = q.left - 1'b1;
              n.uf = UF_RDTX;
            end
            UF_RDTX: begin
              if (!utx_busy && !q.tx_go) begin
                if (q.left == '0) begin
                  fin = 1'b1;
                end else begin
                  n.uf = UF_RDREQ;
                end
              end
            end
            UF_STAT: begin
              if (!utx_busy && !q.tx_go) begin
                n.st = ST_IDLE;
                n.uf = UF_REST;
              end
            end
            UF_REST: begin
              n.st = ST_IDLE;
            end
          endcase
        end
      end
      ST_EXEC: begin
        if (exec_done) begin
          n.cst = (exec_resp.cst != '0) ? exec_resp.cst : `HCB_CST_OK;
          n.tgt = exec_resp.target;
          if (!exec_resp.mode_go) begin
            n.st = ST_IDLE;
          end else if (exec_resp.target == `HCB_MODE_SLEEP) begin
            n.st = ST_SLEEP;
          end else begin
            n.st = ST_SWITCH;
          end
        end
      end
      ST_SWITCH: begin
        // The counter has run since the command ended, so the wait is measured from there.
        if (q.cnt >= sw_cyc(q.mode, q.tgt) && tgt_ready(q.tgt)) begin
          n.mode = q.tgt;
          n.st = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (wake_evt || nss_fall) begin
          n.st = ST_WAKE;
          n.cnt = '0;
          n.warm = retained;
        end
      end
      ST_WAKE: begin
        if (q.cnt >= (q.warm ? CW'(WAKE_WARM_CYC) : CW'(WAKE_COLD_CYC))) begin
          n.mode = `HCB_MODE_RC;
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_BOOT;
    endcase
    // Completion starts the switch clock at the closing edge.
    if (fin) begin
      n.cmd_valid = 1'b1;
      n.st = ST_EXEC;
      n.cnt = '0;
      n.uf = UF_REST;
    end
    if (abort) begin
      n.cst = abort_cst;
      n.st = ST_IDLE;
      n.uf = UF_REST;
      n.spi_act = 1'b0;
    end
    n.busy = (n.st != ST_IDLE);
    n.pin_out = use_uart ? utxd : q.tx_sh[7];
  end

  // Busy is high from reset until calibration completes; select lines idle high.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.busy <= 1'b1;
      q.pin_out <= 1'b1;
      q.nss1 <= 1'b1;
      q.nss2 <= 1'b1;
      q.nss_q <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign serial_out = q.pin_out;
  assign busy = q.busy;
  assign cmd_valid = q.cmd_valid;
  assign cmd_opcode = q.opcode;
  assign par_out = q.par;
  assign rd_req = q.rd_req;
  assign status_out = stat_now;
endmodule // hcb_frontend

// ==== verif/hcb_chk_sva.sv ====
// Port assertions for the host command front end.
`timescale 1ns/10ps
`include "hcb_defines.svh"
module hcb_chk
  import hcb_pkg::*;
(
  input wire logic   clk,           // System clock.
  input wire logic   resetn,        // Reset, active low.
  input wire logic   use_uart,      // Port choice.
  input wire logic   port_select_n, // Select pin, active low.
  input wire logic   busy,          // Busy pin.
  input wire logic   synth_lock,    // Synthesizer locked.
  input wire logic   rx_ready,      // Receive chain ready.
  input wire logic   tx_ramp_done,  // Amplifier ramp done.
  input wire logic   cmd_valid,     // Command framed.
  input hcb_byte_t   par_out,       // Parameter stream.
  input hcb_status_t status_out     // Status byte.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // A mode entry is only trusted when the readiness input was high the edge before.
  chk_stat_busy:
    assert property (status_out.busy == busy) else $error("Status busy bit differs from pin.");
  chk_stat_rsv:
    assert property (status_out.rsv == 1'b0) else $error("Reserved status bit set.");
  chk_cmd_busy:
    assert property (cmd_valid |-> busy) else $error("Command framed while ready.");
  chk_par_busy:
    assert property (par_out.valid |-> busy) else $error("Parameter seen while ready.");
  chk_sel_busy:
    assert property (($fell(port_select_n) && !busy && !use_uart) |-> ##[1:6] busy) else $error("Busy late.");
  chk_fs_lock:
    assert property (($fell(busy) && status_out.mode == `HCB_MODE_FS && $past(status_out.mode) != `HCB_MODE_FS)
      |-> $past(synth_lock)) else $error("Synth entered without lock.");
  chk_rx_ready:
    assert property (($fell(busy) && status_out.mode == `HCB_MODE_RX && $past(status_out.mode) != `HCB_MODE_RX)
      |-> $past(rx_ready)) else $error("Receive entered unready.");
  chk_tx_ramp:
    assert property (($fell(busy) && status_out.mode == `HCB_MODE_TX && $past(status_out.mode) != `HCB_MODE_TX)
      |-> $past(tx_ramp_done)) else $error("Transmit entered before ramp.");
  chk_cst_code:
    assert property ($changed(status_out.cst) |-> status_out.cst != 3'h0) else $error("Reserved command status.");
  chk_mode_code:
    assert property ($changed(status_out.mode) |-> status_out.mode inside {[3'h2:3'h6]}) else $error("Bad mode.");
  cov_fs: cover property ($fell(busy) && status_out.mode == `HCB_MODE_FS);
  cov_cmd: cover property (cmd_valid);
  cov_wdog: cover property (status_out.cst == `HCB_CST_TIMEOUT);
endmodule // hcb_chk

bind hcb_frontend hcb_chk i_chk (.clk(clk), .resetn(resetn), .use_uart(use_uart), .port_select_n(port_select_n),
  .busy(busy), .synth_lock(synth_lock), .rx_ready(rx_ready), .tx_ramp_done(tx_ramp_done), .cmd_valid(cmd_valid),
  .par_out(par_out), .status_out(status_out));

// ==== verif/hcb_host.sv ====
// Host model driving the synchronous command port, mode 0, MSB first.
`timescale 1ns/10ps
module hcb_host (
  input  wire logic clk,   // System clock.
  input  wire logic busy,  // Busy pin.
  input  wire logic miso,  // Status bit from the block.
  output logic      sel_n, // Select, active low.
  output logic      sck,   // Port clock, still between frames.
  output logic      mosi   // Data to the block.
);
  time t_end; // Time of the select rise closing the last frame.
  // Idle levels at time zero.
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // One frame of n bytes from d, first status byte back in st; sck period 160 ns.
  task automatic frame(input logic [23:0] d, input int n, output logic [7:0] st);
    int k;
    k = 0;
    while (busy && k < 9000) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    #1 sel_n = 1'b0;
    #104; // Keeps every sck and mosi change midway between two clock edges.
    for (int i = 0; i < 8 * n; i++) begin
      mosi = d[23-i];
      #40 sck = 1'b1;
      if (i < 8) st[7-i] = miso;
      #80 sck = 1'b0;
      #40;
    end
    // A released line must not keep its last value, or a stale bit could pass.
    mosi = ~mosi;
    @(posedge clk);
    #1 sel_n = 1'b1;
    t_end = $time;
  endtask
endmodule // hcb_host

// ==== verif/tb.sv ====
// Self-checking testbench for the host command front end.
`timescale 1ns/10ps
`include "hcb_defines.svh"
module tb
  import hcb_pkg::*;
;
  logic        clk, resetn, calib_done, synth_lock, rx_ready, tx_ramp_done, wdog_en, exec_done;
  logic        wake_evt, retained, stat_evt, sel_n, sck, mosi, serial_out, busy, cmd_valid, rxd, noparam;
  logic [2:0]  stat_code;
  logic [7:0]  cmd_opcode, st, rdd;
  hcb_exec_t   exec_resp;
  hcb_byte_t   par_out;
  hcb_status_t status_out;
  int          errors, checked, npar, ncmd, nc;

  hcb_frontend #(.US_CYC(1), .WAKE_COLD_CYC(1700), .WAKE_WARM_CYC(250), .WDOG_CYC(300)) i_dut (
    .clk(clk), .resetn(resetn), .use_uart(1'b0), .port_select_n(sel_n), .spi_sck(sck), .spi_mosi(mosi),
    .uart_rxd(rxd), .serial_out(serial_out), .busy(busy), .calib_done(calib_done), .synth_lock(synth_lock),
    .rx_ready(rx_ready), .tx_ramp_done(tx_ramp_done), .wdog_en(wdog_en), .wake_evt(wake_evt),
    .retained(retained), .op_noparam(noparam), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .par_out(par_out),
    .rd_req(), .rd_data(rdd), .exec_done(exec_done), .exec_resp(exec_resp), .stat_evt(stat_evt),
    .stat_code(stat_code), .status_out(status_out));
  hcb_host hst (.clk(clk), .busy(busy), .miso(serial_out), .sel_n(sel_n), .sck(sck), .mosi(mosi));

  // Clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counts framed commands and parameter pulses.
  always @(posedge clk) begin
    if (par_out.valid === 1'b1) npar++;
    if (cmd_valid === 1'b1) ncmd++;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic summarize;
    $display("Checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One command frame, its completion with target tg, then busy fall timed from select rise.
  task automatic go(input logic [2:0] tg, input int lo, input int hi, input int ld);
    int n0, k;
    n0 = ncmd;
    npar = 0;
    hst.frame(24'h860102, 3, st);
    k = 0;
    while (ncmd == n0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk(16'(npar), 16'd2);
    chk(16'(ncmd - n0), 16'd1);
    chk(cmd_opcode, 8'h86);
    @(posedge clk);
    #1 exec_done = 1'b1;
    exec_resp = {1'b1, tg, 3'h0};
    @(posedge clk);
    #1 exec_done = 1'b0;
    // Sleep keeps busy high until a wake event, so there is no switch to time.
    if (tg == `HCB_MODE_SLEEP) return;
    repeat (ld) begin
      @(posedge clk);
      #1 chk(busy, 1'b1);
    end
    synth_lock = 1'b1;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    k = int'(($time - hst.t_end) / 10);
    chk(k >= lo && k <= hi, 1'b1);
    chk(status_out.mode, tg);
  endtask

  // Sleep entry, then a wake that must take the warm or cold time scaled to cycles.
  task automatic t_sleep(input logic r, input int lo);
    int k;
    retained = r;
    go(`HCB_MODE_SLEEP, 0, 0, 0);
    chk(busy, 1'b1);
    @(posedge clk);
    #1 wake_evt = 1'b1;
    @(posedge clk);
    #1 wake_evt = 1'b0;
    k = 1;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk(k >= lo && k <= lo + 6, 1'b1);
    chk(status_out.mode, `HCB_MODE_RC);
  endtask

  // Main sequence: boot, switches, status, watchdog, sleep.
  initial begin
    {resetn, calib_done, synth_lock, rx_ready, tx_ramp_done, wdog_en, exec_done, wake_evt} = '0;
    {retained, stat_evt, stat_code, exec_resp, errors, checked, npar, ncmd} = '0;
    {rxd, noparam, rdd} = 10'h200; // Idle serial line is high.
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (20) @(posedge clk);
    chk(busy, 1'b1);
    #1 calib_done = 1'b1;
    {rx_ready, tx_ramp_done} = 2'b11;
    repeat (5) @(posedge clk);
    chk(status_out, {`HCB_MODE_RC, 3'h0, 2'b00});
    go(`HCB_MODE_FS, 83, 220, 150);
    go(`HCB_MODE_RX, 34, 49, 0);
    hst.frame(24'hC00000, 1, st);
    chk(st, {`HCB_MODE_RX, `HCB_CST_OK, 2'b00});
    @(posedge clk);
    #1 stat_evt = 1'b1;
    stat_code = 3'h2;
    @(posedge clk);
    #1 stat_evt = 1'b0;
    chk(status_out.cst, 3'h2);
    go(`HCB_MODE_TX, 39, 54, 0);
    #1 wdog_en = 1'b1;
    nc = ncmd;
    hst.frame(24'h860102, 3, st);
    repeat (10) @(posedge clk);
    chk(status_out, {`HCB_MODE_TX, `HCB_CST_TIMEOUT, 2'b00});
    chk(16'(ncmd), 16'(nc));
    #1 wdog_en = 1'b0;
    t_sleep(1'b1, `HCB_T_WAKE_WARM_US);
    t_sleep(1'b0, `HCB_T_WAKE_COLD_US);
    summarize();
  end
  // Watchdog against a hung run.
  initial begin
    #500000;
    errors++;
    summarize();
  end
endmodule // tb
